// ==== adcsq_sequencer.sv ====
`timescale 1ns/1ps
// top: AHB-Lite register slave and conversion sequencer
// assumes a successive-approximation array outside that takes a
// trial word and answers with one comparator bit per period
module adcsq_sequencer
    import adcsq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sub_tick,
    input wire logic comp_in,
    output logic [11:0] sar_trial,
    output logic sample_en,
    output logic [3:0] channel_out,
    output logic vref_sel,
    output logic [7:0] analog_pin_enables,
    output logic converter_powered,
    output logic wake_req,
    output logic irq_vector_req
);
    // ======================================================
    // registers
    logic [7:0] analog_pin_enable; // analog pin enables
    logic [7:0] converter_control; // vref, ratio, run, power, channel
    logic [11:0] result; // last completed word
    logic conversion_done_flag; // sticky done flag
    logic done_wake_enable; // wake on done
    logic done_interrupt_enable; // interrupt on done
    logic [7:0] mode_reg; // shs, green, sleep, gie
    logic results_valid; // results loaded since last clear
    // ======================================================
    // sequencer state
    adcsq_state_t state; // one-hot state
    logic [3:0] cnt; // period counter within a phase
    // sar_trial is the working word itself, so no lag at divide by one
    logic [3:0] bitpos; // bit under decision
    logic done_pulse; // one cycle at completion
    adcsq_tick_if tk ();
    // ======================================================
    // bus address phase capture
    logic ph_wr; // pending write data phase
    logic ph_rd; // pending read data phase
    logic [3:0] ph_idx; // latched word index
    logic acc; // valid transfer this cycle
    assign acc = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_idx <= 4'h0;
        end
        else if (hready)
        begin
            ph_wr <= acc && hwrite;
            ph_rd <= acc && !hwrite;
            ph_idx <= haddr[5:2];
        end
    end
    // zero-wait slave: always ready, always okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
    // ======================================================
    // read mux, registered at the address phase so data stands in data phase
    logic [7:0] rd_byte; // selected register
    always_comb
    begin
        case (haddr[5:2])
            ADCSQ_IDX_PIN_EN: rd_byte = analog_pin_enable;
            ADCSQ_IDX_CTRL: rd_byte = converter_control;
            ADCSQ_IDX_RES_HI: rd_byte = result[11:4];
            ADCSQ_IDX_RES_NIB: rd_byte = {4'h0, result[11:8]};
            ADCSQ_IDX_RES_LO: rd_byte = result[7:0];
            ADCSQ_IDX_FLAG_WAKE: rd_byte = {2'b00, conversion_done_flag, 1'b0, done_wake_enable, 3'b000};
            ADCSQ_IDX_IRQ_MASK: rd_byte = {2'b00, done_interrupt_enable, 5'h00};
            ADCSQ_IDX_MODE: rd_byte = mode_reg;
            default: rd_byte = 8'h00;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (acc && !hwrite)
            hrdata <= {24'h000000, rd_byte};
    end
    // ======================================================
    // register writes
    logic wr_ctrl; // write to converter_control
    assign wr_ctrl = ph_wr && ph_idx == ADCSQ_IDX_CTRL;
    logic chan_wr_ok; // channel field writable
    // channel locked while done or running
    assign chan_wr_ok = !conversion_done_flag && !converter_control[ADCSQ_CTRL_RUN];
    logic in_sleep; // core is in sleep
    assign in_sleep = mode_reg[ADCSQ_MD_SLEEP];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            converter_control <= ADCSQ_RST_CTRL;
        else
        begin
            if (wr_ctrl)
            begin
                converter_control[7:5] <= hwdata[7:5];
                converter_control[ADCSQ_CTRL_PWR] <= hwdata[ADCSQ_CTRL_PWR];
                if (chan_wr_ok)
                    converter_control[2:0] <= hwdata[2:0];
            end
            if (done_pulse)
                converter_control[ADCSQ_CTRL_RUN] <= 1'b0;
            // only a one from software sets run
            else if (wr_ctrl && hwdata[ADCSQ_CTRL_RUN])
                converter_control[ADCSQ_CTRL_RUN] <= 1'b1;
            // sleep end without interrupt powers off
            if (done_pulse && in_sleep && !done_interrupt_enable)
                converter_control[ADCSQ_CTRL_PWR] <= 1'b0;
        end
    end
    // other writable registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            analog_pin_enable <= 8'h00;
            done_wake_enable <= 1'b0;
            done_interrupt_enable <= 1'b0;
            mode_reg <= ADCSQ_RST_MODE;
        end
        else if (ph_wr)
        begin
            case (ph_idx)
                ADCSQ_IDX_PIN_EN: analog_pin_enable <= hwdata[7:0];
                ADCSQ_IDX_FLAG_WAKE: done_wake_enable <= hwdata[ADCSQ_FW_WAKE_EN];
                ADCSQ_IDX_IRQ_MASK: done_interrupt_enable <= hwdata[ADCSQ_IM_DONE_IE];
                ADCSQ_IDX_MODE: mode_reg <= {1'b0, hwdata[6:2], 2'b00};
                default: ;
            endcase
            // a wake in a write cycle still clears the marker
            if (wake_req)
                mode_reg[ADCSQ_MD_SLEEP] <= 1'b0;
        end
        // wake clears the sleep marker
        else if (wake_req)
            mode_reg[ADCSQ_MD_SLEEP] <= 1'b0;
    end
    // done flag: set wins over software clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            conversion_done_flag <= 1'b0;
        else if (done_pulse)
            conversion_done_flag <= 1'b1;
        else if (ph_wr && ph_idx == ADCSQ_IDX_FLAG_WAKE && !hwdata[ADCSQ_FW_DONE])
            conversion_done_flag <= 1'b0;
    end
    // ======================================================
    // divider hookup
    assign tk.ratio = converter_control[6:5];
    assign tk.green = mode_reg[ADCSQ_MD_GREEN];
    assign tk.sub_tick = sub_tick;
    assign tk.run = (state != ADCSQ_IDLE);
    adcsq_divider u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .tk(tk)
    );
    // sample length in periods
    logic [3:0] shs_len; // minus one
    // 2, 4, 8 or 12 periods
    always_comb
    begin
        case (mode_reg[3:2])
            2'b00: shs_len = 4'h1;
            2'b01: shs_len = 4'h3;
            2'b10: shs_len = 4'h7;
            default: shs_len = 4'hB;
        endcase
    end
    // ======================================================
    // sequencer; sleep has no effect on it
    // keeps running in sleep
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= ADCSQ_IDLE;
            cnt <= 4'h0;
            sar_trial <= 12'h000;
            bitpos <= 4'h0;
            done_pulse <= 1'b0;
        end
        else
        begin
            done_pulse <= 1'b0;
            case (state)
                // run bit with power on starts
                ADCSQ_IDLE:
                    if (converter_control[ADCSQ_CTRL_RUN] && converter_control[ADCSQ_CTRL_PWR] && !done_pulse)
                    begin
                        state <= ADCSQ_DELAY;
                        cnt <= 4'h0;
                    end
                ADCSQ_DELAY:
                    if (tk.tick)
                    begin
                        if (cnt >= ADCSQ_START_DELAY - 4'h1)
                        begin
                            state <= ADCSQ_SAMPLE;
                            cnt <= 4'h0;
                        end
                        else
                            cnt <= cnt + 4'h1;
                    end
                ADCSQ_SAMPLE:
                    if (tk.tick)
                    begin
                        if (cnt >= shs_len)
                        begin
                            state <= ADCSQ_CONVERT;
                            bitpos <= 4'hB;
                            sar_trial <= 12'h800;
                        end
                        else
                            cnt <= cnt + 4'h1;
                    end
                ADCSQ_CONVERT:
                    if (tk.tick)
                    begin
                        sar_trial[bitpos] <= comp_in;
                        if (bitpos == 4'h0)
                            state <= ADCSQ_FINISH;
                        else
                        begin
                            sar_trial[bitpos - 4'h1] <= 1'b1;
                            bitpos <= bitpos - 4'h1;
                        end
                    end
                ADCSQ_FINISH:
                begin
                    state <= ADCSQ_IDLE;
                    done_pulse <= 1'b1;
                end
                default: state <= ADCSQ_IDLE;
            endcase
        end
    end
    // ======================================================
    // result registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            result <= 12'h000;
            results_valid <= 1'b0;
        end
        else if (state == ADCSQ_FINISH)
        begin
            result <= sar_trial;
            results_valid <= 1'b1;
        end
        else if (wr_ctrl && chan_wr_ok && results_valid && hwdata[2:0] != converter_control[2:0])
        begin
            result <= 12'h000;
            results_valid <= 1'b0;
        end
    end
    // ======================================================
    // outputs to the analog side and core
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sample_en <= 1'b0;
            channel_out <= 4'h0;
            vref_sel <= 1'b0;
            analog_pin_enables <= 8'h00;
            converter_powered <= 1'b0;
            wake_req <= 1'b0;
            irq_vector_req <= 1'b0;
        end
        else
        begin
            sample_en <= converter_control[ADCSQ_CTRL_PWR] && (state == ADCSQ_IDLE || state == ADCSQ_DELAY
                || (state == ADCSQ_SAMPLE && !(tk.tick && cnt >= shs_len)));
            channel_out <= {1'b0, converter_control[2:0]};
            vref_sel <= converter_control[ADCSQ_CTRL_VREF];
            analog_pin_enables <= analog_pin_enable;
            converter_powered <= converter_control[ADCSQ_CTRL_PWR];
            // wake on done, interrupt enable also wakes
            wake_req <= done_pulse && in_sleep && (done_wake_enable || done_interrupt_enable);
            irq_vector_req <= done_pulse && done_interrupt_enable && mode_reg[ADCSQ_MD_GIE];
        end
    end
endmodule // adcsq_sequencer

// ==== adcsq_pkg.sv ====
// package of constants for the converter sequencer block
// assumes a word-aligned AHB-Lite slave; one clock, hclk at 125 MHz
// Function
// - sample phase, twelve bit periods, start delay
// - converter keeps running while core sleeps
// - completion clears run bit, sets done flag
// - done-wake enable wakes sleeping core
// - interrupt enable plus global enable vectors
// - interrupts globally off: wake, no vector
// - completion loads three result registers
// - sleep end without interrupt powers converter off
// - power-on bit starts sampling selected input
// - writing run bit starts conversion sequence
// - channel change after completion clears results
// - clock ratio field divides main clock
// - software zero write to run ignored
// - channel writable only when done and run low
// - sample phase of 2,4,8,12 periods
package adcsq_pkg;
    // ======================================================
    // register word indices; the byte address is four times the index
    localparam logic [3:0] ADCSQ_IDX_PIN_EN = 4'h8;
    localparam logic [3:0] ADCSQ_IDX_CTRL = 4'h9;
    localparam logic [3:0] ADCSQ_IDX_RES_HI = 4'hB;
    localparam logic [3:0] ADCSQ_IDX_RES_NIB = 4'hC;
    localparam logic [3:0] ADCSQ_IDX_RES_LO = 4'hD;
    localparam logic [3:0] ADCSQ_IDX_FLAG_WAKE = 4'hE;
    localparam logic [3:0] ADCSQ_IDX_IRQ_MASK = 4'hF;
    localparam logic [3:0] ADCSQ_IDX_MODE = 4'h7;
    // ======================================================
    // converter_control field positions
    localparam int ADCSQ_CTRL_VREF = 7;
    localparam int ADCSQ_CTRL_CKR = 5;
    localparam int ADCSQ_CTRL_RUN = 4;
    localparam int ADCSQ_CTRL_PWR = 3;
    localparam int ADCSQ_CTRL_CH = 0;
    // flag_and_wake_sfr positions
    localparam int ADCSQ_FW_DONE = 5;
    localparam int ADCSQ_FW_WAKE_EN = 3;
    // interrupt mask position
    localparam int ADCSQ_IM_DONE_IE = 5;
    // mode register: sample_hold_select, green, sleep, global ie
    localparam int ADCSQ_MD_SHS = 2;
    localparam int ADCSQ_MD_GREEN = 4;
    localparam int ADCSQ_MD_SLEEP = 5;
    localparam int ADCSQ_MD_GIE = 6;
    // ======================================================
    // reset values
    localparam logic [7:0] ADCSQ_RST_CTRL = 8'h00;
    localparam logic [7:0] ADCSQ_RST_MODE = 8'h0C;
    // ======================================================
    // timing
    localparam int ADCSQ_BITS = 12;
    localparam logic [3:0] ADCSQ_START_DELAY = 4'h1;
    localparam logic [31:0] ADCSQ_IRQ_VECTOR = 32'h0000000C;
    // ======================================================
    // sequencer states, one-hot
    typedef enum logic [4:0] {
        ADCSQ_IDLE = 5'b00001,
        ADCSQ_DELAY = 5'b00010,
        ADCSQ_SAMPLE = 5'b00100,
        ADCSQ_CONVERT = 5'b01000,
        ADCSQ_FINISH = 5'b10000
    } adcsq_state_t;
endpackage

// ==== adcsq_tick_if.sv ====
`timescale 1ns/1ps
// carrier between the sequencer and its clock divider
// assumes both ends share hclk
interface adcsq_tick_if;
    logic [1:0] ratio; // clock_ratio_select
    logic green; // low-speed green mode
    logic sub_tick; // sub-oscillator tick
    logic run; // divider runs only during a conversion
    logic tick; // one converter_clock_period boundary
    modport ctl (output ratio, output green, output sub_tick, output run, input tick);
    modport div (input ratio, input green, input sub_tick, input run, output tick);
endinterface

// ==== adcsq_divider.sv ====
`timescale 1ns/1ps
// converter clock enable from main clock or sub tick
// assumes the sub tick is already synchronous to hclk
module adcsq_divider
    import adcsq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    adcsq_tick_if.div tk
);
    // ======================================================
    // divide counter
    logic [5:0] cnt; // counts main clocks in one period
    logic [5:0] last; // terminal count for the ratio
    always_comb
    begin
        case (tk.ratio)
            2'b00: last = 6'h0F;
            2'b01: last = 6'h03;
            2'b10: last = 6'h3F;
            default: last = 6'h00;
        endcase
    end
    // counter-based enable, restarts at each run
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt <= 6'h00;
            tk.tick <= 1'b0;
        end
        else if (!tk.run)
        begin
            cnt <= 6'h00;
            tk.tick <= 1'b0;
        end
        else if (tk.green)
        begin
            cnt <= 6'h00;
            tk.tick <= tk.sub_tick;
        end
        else if (cnt >= last)
        begin
            cnt <= 6'h00;
            tk.tick <= 1'b1;
        end
        else
        begin
            cnt <= cnt + 6'h01;
            tk.tick <= 1'b0;
        end
    end
endmodule // adcsq_divider

// ==== adcsq_monitor.sv ====
// checker on the top ports of the converter sequencer
// assumes one hclk domain and zero-wait bus answers
`timescale 1ns/1ps
module adcsq_monitor
    import adcsq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic sample_en,
    input wire logic [3:0] channel_out,
    input wire logic vref_sel,
    input wire logic [7:0] analog_pin_enables,
    input wire logic converter_powered,
    input wire logic wake_req,
    input wire logic irq_vector_req
);
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ==========================================
    // write data phase tracking
    logic wr_p; // a write is in its data phase
    logic [3:0] wr_i; // word index of that write
    // a write lands after its data phase, so keep the address
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            wr_p <= 1'b0;
        else
            wr_p <= hsel && hready && htrans[1] && hwrite;
    // no reset needed: only looked at beside wr_p
    always_ff @(posedge hclk)
        wr_i <= haddr[5:2];
    // ==========================================
    // assertions
    a_wake_single: assert property (wake_req |=> !wake_req)
        else $error("wake request longer than one cycle");
    a_vector_single: assert property (irq_vector_req |=> !irq_vector_req)
        else $error("vector request longer than one cycle");
    a_sample_powered: assert property (sample_en |-> converter_powered)
        else $error("sampling while unpowered");
    a_power_write: assert property (wr_p && wr_i == ADCSQ_IDX_CTRL
        |=> ##1 converter_powered == $past(hwdata[ADCSQ_CTRL_PWR], 2)) else $error("power write lost");
    a_vref_write: assert property (wr_p && wr_i == ADCSQ_IDX_CTRL
        |=> ##1 vref_sel == $past(hwdata[ADCSQ_CTRL_VREF], 2)) else $error("reference write lost");
    a_pins_write: assert property (wr_p && wr_i == ADCSQ_IDX_PIN_EN
        |=> ##1 analog_pin_enables == $past(hwdata[7:0], 2)) else $error("pin enable write lost");
    a_channel_frozen: assert property ((converter_powered && !sample_en)[*2] |-> $stable(channel_out))
        else $error("channel moved during bit decisions");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    c_wake: cover property (wake_req);
    c_vector: cover property (irq_vector_req);
    c_power_off: cover property ($fell(converter_powered));
endmodule // adcsq_monitor

bind adcsq_sequencer adcsq_monitor u_adcsq_monitor (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .sample_en, .channel_out, .vref_sel, .analog_pin_enables, .converter_powered, .wake_req, .irq_vector_req
);

// ==== adcsq_analog_model.sv ====
// analog inputs and sub oscillator facing the sequencer
// assumes comparator high means input at or above the trial word
`timescale 1ns/1ps
module adcsq_analog_model
    import adcsq_pkg::*;
#(
    parameter int SUB_DIV = 6
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [11:0] sar_trial,
    input wire logic sample_en,
    input wire logic [3:0] channel_out,
    output logic comp_in,
    output logic sub_tick
);
    int sub_cnt; // sub oscillator phase
    logic wobble; // junk level outside decisions
    logic [11:0] vin; // level on the selected input
    // each channel has its own fixed level
    assign vin = 12'h9A7 + 12'h131 * {9'h000, channel_out[2:0]};
    // no kind answer while sampling: the comparator flips each cycle
    assign comp_in = sample_en ? wobble : (vin >= sar_trial);
    // sub oscillator runs free, one tick every SUB_DIV cycles
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            sub_cnt <= 0;
        else
            sub_cnt <= (sub_cnt == SUB_DIV - 1) ? 0 : sub_cnt + 1;
    assign sub_tick = (sub_cnt == SUB_DIV - 1);
    // toggling pattern
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            wobble <= 1'b0;
        else
            wobble <= !wobble;
endmodule // adcsq_analog_model

// ==== adcsq_sequencer_tb.sv ====
// bench for the converter sequencer: AHB-Lite master tasks
// assumes the analog model as far side and hready tied to hreadyout
`timescale 1ns/1ps
module adcsq_sequencer_tb
    import adcsq_pkg::*;
;
    localparam int SUB_DIV = 6; // sub tick spacing in hclk cycles
    localparam logic [7:0] A_PIN = {2'b00, ADCSQ_IDX_PIN_EN, 2'b00};
    localparam logic [7:0] A_CTRL = {2'b00, ADCSQ_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_HI = {2'b00, ADCSQ_IDX_RES_HI, 2'b00};
    localparam logic [7:0] A_NIB = {2'b00, ADCSQ_IDX_RES_NIB, 2'b00};
    localparam logic [7:0] A_LO = {2'b00, ADCSQ_IDX_RES_LO, 2'b00};
    localparam logic [7:0] A_FW = {2'b00, ADCSQ_IDX_FLAG_WAKE, 2'b00};
    localparam logic [7:0] A_IM = {2'b00, ADCSQ_IDX_IRQ_MASK, 2'b00};
    localparam logic [7:0] A_MODE = {2'b00, ADCSQ_IDX_MODE, 2'b00};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2; // whole words only
    logic hready, hreadyout, hresp, comp_in, sub_tick, sample_en, vref_sel, converter_powered, wake_req, irq_vector_req;
    logic [31:0] hrdata;
    logic [11:0] sar_trial;
    logic [3:0] channel_out;
    logic [7:0] analog_pin_enables;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0; // clock count
    int t_start = 0; // cycle of the last start
    int wakes = 0; // wake pulses seen
    int irqs = 0; // vector pulses seen
    assign hready = hreadyout;
    initial forever #4 hclk = ~hclk;
    // pulse counters: pulses stand one cycle, so look at every edge
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        wakes <= wakes + int'(wake_req === 1'b1);
        irqs <= irqs + int'(irq_vector_req === 1'b1);
    end
    adcsq_sequencer u_adcsq_sequencer (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .sub_tick, .comp_in, .sar_trial, .sample_en, .channel_out,
        .vref_sel, .analog_pin_enables, .converter_powered, .wake_req, .irq_vector_req);
    adcsq_analog_model #(.SUB_DIV(SUB_DIV)) u_adcsq_analog_model (.hclk, .hresetn, .sar_trial, .sample_en,
        .channel_out, .comp_in, .sub_tick);
    // ==========================================
    // compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rng(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi)
        begin
            errors++;
            $display("MISMATCH t=%0t span %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // ==========================================
    // bus tasks: hold each phase until hready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h0;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp, what);
    endtask
    // start a conversion and note when
    task automatic go(input logic [7:0] c);
        wr(A_CTRL, {24'h0, c});
        t_start = cyc;
    endtask
    // poll run, then check span, flag and results of channel ch
    task automatic finish(input int n, input int div, input int ch);
        logic [31:0] q;
        logic [11:0] v;
        q = 32'h10;
        v = 12'h9A7 + 12'h131 * ch[11:0];
        while (q[4] !== 1'b0 && cyc - t_start < 4000)
            bus(1'b0, A_CTRL, 32'h0, q);
        chk({31'h0, q[4]}, 32'h0, "run bit");
        rng(cyc - t_start, n * div, n * div + div + 16);
        bus(1'b0, A_FW, 32'h0, q);
        chk(q & 32'h20, 32'h20, "done flag");
        rdc(A_HI, {24'h0, v[11:4]}, "high byte");
        rdc(A_NIB, {28'h0, v[11:8]}, "upper nibble");
        rdc(A_LO, {24'h0, v[7:0]}, "low byte");
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        int dv[4] = '{16, 4, 64, 1};
        int sp[4] = '{2, 4, 8, 12};
        logic [7:0] cf[5] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0] ci[5] = '{8'h00, 8'h20, 8'h20, 8'h20, 8'h00};
        logic [7:0] cm[5] = '{8'h20, 8'h20, 8'h60, 8'h40, 8'h20};
        int cw[5] = '{1, 1, 1, 0, 0};
        int cq[5] = '{0, 0, 1, 1, 0};
        logic cp[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        int k, r, s, w0, i0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(A_CTRL, 32'h00, "control reset");
        rdc(A_MODE, 32'h0C, "mode reset");
        wr(8'h00, 32'hFF);
        rdc(8'h00, 32'h00, "unmapped");
        wr(A_PIN, 32'hA5);
        rdc(A_PIN, 32'hA5, "pin enables");
        chk({24'h0, analog_pin_enables}, 32'hA5, "pin port");
        // reference select and channel output checked after each conversion
        // every ratio at eight-period sampling, then the other sample lengths
        for (k = 0; k < 7; k++)
        begin
            r = k < 4 ? k : 3;
            s = k < 4 ? 2 : (k == 6 ? 3 : k - 4);
            wr(A_MODE, s << 2);
            go({k[0], r[1:0], 2'b11, k[2:0]});
            finish(13 + sp[s], dv[r], k);
            chk({31'h0, vref_sel}, {31'h0, k[0]}, "reference select");
            chk({28'h0, channel_out}, {29'h0, k[2:0]}, "channel out");
            wr(A_FW, 32'h00);
        end
        // zero to run and a channel change mid-conversion are ignored
        wr(A_MODE, 32'h08);
        go(8'h1F);
        wr(A_CTRL, 32'h0B);
        rdc(A_CTRL, 32'h1F, "run and channel held");
        finish(21, 16, 7);
        wr(A_CTRL, 32'h0A);
        rdc(A_CTRL, 32'h0F, "channel held by flag");
        wr(A_FW, 32'h00);
        wr(A_CTRL, 32'h0A);
        rdc(A_HI, 32'h00, "high cleared");
        rdc(A_NIB, 32'h00, "nibble cleared");
        rdc(A_LO, 32'h00, "low cleared");
        chk({28'h0, channel_out}, 32'h2, "channel taken");
        // sleep, wake and vector cases
        for (k = 0; k < 5; k++)
        begin
            wr(A_FW, {24'h0, cf[k]});
            wr(A_IM, {24'h0, ci[k]});
            wr(A_MODE, {24'h0, cm[k]});
            w0 = wakes;
            i0 = irqs;
            go(8'h78 | k[7:0]);
            finish(15, 1, k);
            rng(wakes - w0, cw[k], cw[k]);
            rng(irqs - i0, cq[k], cq[k]);
            chk({31'h0, converter_powered}, {31'h0, cp[k]}, "power after done");
            wr(A_FW, 32'h00);
            wr(A_MODE, 32'h00);
        end
        // green mode runs from the sub tick whatever the ratio
        wr(A_MODE, 32'h18);
        go(8'h58);
        finish(21, SUB_DIV, 0);
        close_out;
    end
    // watchdog, far beyond the few thousand cycles needed
    initial
    begin
        #160000;
        errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out;
    end
endmodule // adcsq_sequencer_tb
